// >>> logic/rrc_caps_regs.sv
// remote receiver capability register bank for both link ports
//
// Behaviour
// - hold flag bit 7 blocks channel reloads; software values at 0x20/0x21 stay.
// - bit 6 holds mode bit 0; mode bits 2:1 live in caps_2.
// - on receive lock detect, load mode and training bits unless held.
// - bit 5 set requests the frequency training pattern on the link.
// - bit 4 set requests the equalization training pattern on the link.
// - each link port keeps its own copy; select shows the second copy.
// - mode codes: normal, gpio 1/2/4, reserved, forward spi, reverse spi.
// - select bit routes primary-address accesses to the second port.
module rrc_caps_regs
    import rrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic second_port_view_select,
    input wire logic [1:0] rx_lock,
    input wire logic [2:0] bcc_mode_p0,
    input wire logic [2:0] bcc_mode_p1,
    input wire logic [1:0] bcc_freq,
    input wire logic [1:0] bcc_eq,
    output logic [7:0] reg_rdata,
    output logic [1:0] freq_training_request,
    output logic [1:0] eq_training_request,
    output logic [2:0] fast_ctrl_channel_mode_p0,
    output logic [2:0] fast_ctrl_channel_mode_p1,
    output rrc_kind_t fast_ctrl_channel_kind_p0,
    output rrc_kind_t fast_ctrl_channel_kind_p1
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // mode decode is needed for both ports
    function automatic rrc_kind_t mode_kind(input logic [2:0] mode);
        rrc_kind_t k;
        case (mode)
            RRC_MODE_NORMAL: k = RRC_KIND_NORMAL;
            RRC_MODE_GPIO1: k = RRC_KIND_GPIO1;
            RRC_MODE_GPIO2: k = RRC_KIND_GPIO2;
            RRC_MODE_GPIO4: k = RRC_KIND_GPIO4;
            RRC_MODE_FWD_SPI: k = RRC_KIND_FWD_SPI;
            RRC_MODE_REV_SPI: k = RRC_KIND_REV_SPI;
            default: k = RRC_KIND_RESERVED;
        endcase
        return k;
    endfunction

    // build the caps_1 read image from one port's fields
    function automatic logic [7:0] caps1_image(input logic hold, input logic [2:0] mode,
                                               input logic freq, input logic eq);
        logic [7:0] v;
        v = RRC_READ_ZERO;
        v[RRC_HOLD_BIT] = hold;
        v[RRC_MODE0_BIT] = mode[0];
        v[RRC_FREQ_BIT] = freq;
        v[RRC_EQ_BIT] = eq;
        return v;
    endfunction

    // ------------------------------------------------------------
    // receive lock synchronisers and rising-edge detect
    // ------------------------------------------------------------
    logic [1:0] lock_meta_reg;
    logic [1:0] lock_sync_reg;
    logic [1:0] lock_prev_reg;
    logic [1:0] lock_rise;

    // lock comes from the link receiver, outside this clock domain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lock_meta_reg <= 2'h0;
            lock_sync_reg <= 2'h0;
            lock_prev_reg <= 2'h0;
        end
        else if (ce)
        begin
            lock_meta_reg <= rx_lock;
            lock_sync_reg <= lock_meta_reg;
            lock_prev_reg <= lock_sync_reg;
        end
    end

    assign lock_rise = lock_sync_reg & ~lock_prev_reg;

    // ------------------------------------------------------------
    // write steering by port select
    // ------------------------------------------------------------
    logic hit_caps1;
    logic hit_caps2;
    logic [1:0] port_wr1;
    logic [1:0] port_wr2;

    assign hit_caps1 = reg_wr && (reg_addr == RRC_CAPS1_OFFSET);
    assign hit_caps2 = reg_wr && (reg_addr == RRC_CAPS2_OFFSET);
    // software must set hold alongside its values, else a lock event overwrites them
    assign port_wr1 = {hit_caps1 && second_port_view_select,
                       hit_caps1 && !second_port_view_select};
    assign port_wr2 = {hit_caps2 && second_port_view_select,
                       hit_caps2 && !second_port_view_select};

    // ------------------------------------------------------------
    // per-port copies
    // ------------------------------------------------------------
    logic [1:0] hold_remote_caps;

    rrc_port_caps port0_caps
    (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_caps1(port_wr1[0]),
        .wr_caps2(port_wr2[0]),
        .wdata(reg_wdata),
        .lock_rise(lock_rise[0]),
        .bcc_mode(bcc_mode_p0),
        .bcc_freq(bcc_freq[0]),
        .bcc_eq(bcc_eq[0]),
        .hold_remote_caps(hold_remote_caps[0]),
        .fast_ctrl_channel_mode(fast_ctrl_channel_mode_p0),
        .freq_training_request(freq_training_request[0]),
        .eq_training_request(eq_training_request[0])
    );

    rrc_port_caps port1_caps
    (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_caps1(port_wr1[1]),
        .wr_caps2(port_wr2[1]),
        .wdata(reg_wdata),
        .lock_rise(lock_rise[1]),
        .bcc_mode(bcc_mode_p1),
        .bcc_freq(bcc_freq[1]),
        .bcc_eq(bcc_eq[1]),
        .hold_remote_caps(hold_remote_caps[1]),
        .fast_ctrl_channel_mode(fast_ctrl_channel_mode_p1),
        .freq_training_request(freq_training_request[1]),
        .eq_training_request(eq_training_request[1])
    );

    // ------------------------------------------------------------
    // decoded mode, registered so the outputs stay flop-driven
    // ------------------------------------------------------------
    // costs one cycle of lag behind the mode field; consumers only need the level
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fast_ctrl_channel_kind_p0 <= RRC_KIND_NORMAL;
            fast_ctrl_channel_kind_p1 <= RRC_KIND_NORMAL;
        end
        else if (ce)
        begin
            fast_ctrl_channel_kind_p0 <= mode_kind(fast_ctrl_channel_mode_p0);
            fast_ctrl_channel_kind_p1 <= mode_kind(fast_ctrl_channel_mode_p1);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] read_next;

    // select chooses which port's copy answers
    always_comb
    begin
        read_next = RRC_READ_ZERO;
        if (reg_addr == RRC_CAPS1_OFFSET)
        begin
            if (second_port_view_select)
                read_next = caps1_image(hold_remote_caps[1], fast_ctrl_channel_mode_p1,
                                        freq_training_request[1], eq_training_request[1]);
            else
                read_next = caps1_image(hold_remote_caps[0], fast_ctrl_channel_mode_p0,
                                        freq_training_request[0], eq_training_request[0]);
        end
        else if (reg_addr == RRC_CAPS2_OFFSET)
        begin
            if (second_port_view_select)
                read_next[RRC_MODE_HI_MSB:RRC_MODE_HI_LSB] = fast_ctrl_channel_mode_p1[2:1];
            else
                read_next[RRC_MODE_HI_MSB:RRC_MODE_HI_LSB] = fast_ctrl_channel_mode_p0[2:1];
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= RRC_RESET_VALUE;
        else if (ce && reg_rd)
            reg_rdata <= read_next;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    hold_blocks_load_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && lock_rise[0] && hold_remote_caps[0] && !port_wr1[0] && !port_wr2[0])
        |=> $stable(fast_ctrl_channel_mode_p0) && $stable(freq_training_request[0]))
        else $error("held port0 caps changed on lock");

    mode_bit_six_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && reg_rd && reg_addr == RRC_CAPS1_OFFSET && !second_port_view_select)
        |=> reg_rdata[RRC_MODE0_BIT] == $past(fast_ctrl_channel_mode_p0[0]))
        else $error("caps1 bit 6 is not mode bit 0");

    lock_load_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && lock_rise[1] && !hold_remote_caps[1])
        |=> fast_ctrl_channel_mode_p1 == $past(bcc_mode_p1)
            && eq_training_request[1] == $past(bcc_eq[1]))
        else $error("port1 caps not loaded on lock");

    // an unheld port must take the channel values at every lock edge, also after a hold
    reload_after_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && lock_rise[0] && !hold_remote_caps[0])
        |=> fast_ctrl_channel_mode_p0 == $past(bcc_mode_p0)
            && freq_training_request[0] == $past(bcc_freq[0]))
        else $error("unheld port0 caps not reloaded on lock");

    freq_write_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && port_wr1[0] && !lock_rise[0])
        |=> freq_training_request[0] == $past(reg_wdata[RRC_FREQ_BIT]))
        else $error("freq request not written");

    eq_write_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && port_wr1[1] && !lock_rise[1])
        |=> eq_training_request[1] == $past(reg_wdata[RRC_EQ_BIT]))
        else $error("eq request not written");

    port_isolation_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && reg_wr && second_port_view_select && !lock_rise[0])
        |=> $stable(hold_remote_caps[0]) && $stable(fast_ctrl_channel_mode_p0))
        else $error("port1 write touched port0");

    mode_decode_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && fast_ctrl_channel_mode_p0 == RRC_MODE_FWD_SPI)
        |=> fast_ctrl_channel_kind_p0 == RRC_KIND_FWD_SPI)
        else $error("mode 110 not decoded as forward spi");

    select_route_a: assert property (
        @(posedge clk) disable iff (reset)
        (ce && hit_caps2 && second_port_view_select && !lock_rise[1])
        |=> fast_ctrl_channel_mode_p1[2:1] == $past(reg_wdata[1:0]))
        else $error("select did not route write to port1");

endmodule

// >>> shared/rrc_pkg.sv
// constants and types shared by the remote receiver capability registers
package rrc_pkg;

    // ------------------------------------------------------------
    // register offsets and reset value
    // ------------------------------------------------------------
    localparam logic [7:0] RRC_CAPS1_OFFSET = 8'h20;
    localparam logic [7:0] RRC_CAPS2_OFFSET = 8'h21;
    localparam logic [7:0] RRC_RESET_VALUE = 8'h00;
    localparam logic [7:0] RRC_READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // field positions inside caps_1 and caps_2
    // ------------------------------------------------------------
    localparam int RRC_HOLD_BIT = 7;
    localparam int RRC_MODE0_BIT = 6;
    localparam int RRC_FREQ_BIT = 5;
    localparam int RRC_EQ_BIT = 4;
    localparam int RRC_MODE_HI_MSB = 1;
    localparam int RRC_MODE_HI_LSB = 0;

    // ------------------------------------------------------------
    // fast control channel mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] RRC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] RRC_MODE_GPIO1 = 3'h1;
    localparam logic [2:0] RRC_MODE_GPIO2 = 3'h2;
    localparam logic [2:0] RRC_MODE_GPIO4 = 3'h3;
    localparam logic [2:0] RRC_MODE_FWD_SPI = 3'h6;
    localparam logic [2:0] RRC_MODE_REV_SPI = 3'h7;

    // decoded meaning of the fast control channel mode
    typedef enum logic [2:0]
    {
        RRC_KIND_NORMAL,
        RRC_KIND_GPIO1,
        RRC_KIND_GPIO2,
        RRC_KIND_GPIO4,
        RRC_KIND_RESERVED,
        RRC_KIND_FWD_SPI,
        RRC_KIND_REV_SPI
    } rrc_kind_t;

endpackage

// >>> logic/rrc_port_caps.sv
// one link port's copy of the capability fields with lock-time loading
module rrc_port_caps
    import rrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wr_caps1,
    input wire logic wr_caps2,
    input wire logic [7:0] wdata,
    input wire logic lock_rise,
    input wire logic [2:0] bcc_mode,
    input wire logic bcc_freq,
    input wire logic bcc_eq,
    output logic hold_remote_caps,
    output logic [2:0] fast_ctrl_channel_mode,
    output logic freq_training_request,
    output logic eq_training_request
);

    // ------------------------------------------------------------
    // hold flag: written by software only
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hold_remote_caps <= RRC_RESET_VALUE[RRC_HOLD_BIT];
        else if (ce && wr_caps1)
            hold_remote_caps <= wdata[RRC_HOLD_BIT];
    end

    // ------------------------------------------------------------
    // capability fields: lock-time load wins over a write in the same
    // cycle so that a link event is never lost, but only while unheld
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fast_ctrl_channel_mode <= RRC_RESET_VALUE[2:0];
            freq_training_request <= RRC_RESET_VALUE[RRC_FREQ_BIT];
            eq_training_request <= RRC_RESET_VALUE[RRC_EQ_BIT];
        end
        else if (ce)
        begin
            if (lock_rise && !hold_remote_caps)
            begin
                fast_ctrl_channel_mode <= bcc_mode;
                freq_training_request <= bcc_freq;
                eq_training_request <= bcc_eq;
            end
            else
            begin
                if (wr_caps1)
                begin
                    fast_ctrl_channel_mode[0] <= wdata[RRC_MODE0_BIT];
                    freq_training_request <= wdata[RRC_FREQ_BIT];
                    eq_training_request <= wdata[RRC_EQ_BIT];
                end
                if (wr_caps2)
                    fast_ctrl_channel_mode[2:1] <= wdata[RRC_MODE_HI_MSB:RRC_MODE_HI_LSB];
            end
        end
    end

endmodule

// >>> sim/rrc_remote_rx_model.sv
// model of the remote receiver as seen through the control channel: lock and learned caps
module rrc_remote_rx_model
(
    input wire logic clk,
    output logic [1:0] rx_lock = 2'h0,
    output logic [2:0] bcc_mode_p0 = 3'h0,
    output logic [2:0] bcc_mode_p1 = 3'h0,
    output logic [1:0] bcc_freq = 2'h0,
    output logic [1:0] bcc_eq = 2'h0
);
    timeunit 1ns;
    timeprecision 100ps;

    // start unlocked with caps clear; initialisers keep the task as the only driver
    // ------------------------------------------------------------
    // drop lock, present new caps, regain lock 4+dly cycles later
    // ------------------------------------------------------------
    // until a cycle before lock the caps lines show inverted values, so a stale value never passes
    task automatic lock_port(input int p, input logic [2:0] m, input logic f, input logic e,
                             input int dly);
        @(posedge clk);
        rx_lock[p] <= 1'b0;
        if (p == 0)
            bcc_mode_p0 <= ~m;
        else
            bcc_mode_p1 <= ~m;
        bcc_freq[p] <= ~f;
        bcc_eq[p] <= ~e;
        repeat (3 + dly) @(posedge clk);
        if (p == 0)
            bcc_mode_p0 <= m;
        else
            bcc_mode_p1 <= m;
        bcc_freq[p] <= f;
        bcc_eq[p] <= e;
        // caps settle a cycle before lock so they are stable when lock rises
        @(posedge clk);
        rx_lock[p] <= 1'b1;
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the remote receiver capability register bank
module tb_top
    import rrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic second_port_view_select = 1'b0;
    logic [1:0] rx_lock;
    logic [2:0] bcc_mode_p0;
    logic [2:0] bcc_mode_p1;
    logic [1:0] bcc_freq;
    logic [1:0] bcc_eq;
    logic [7:0] reg_rdata;
    logic [1:0] freq_training_request;
    logic [1:0] eq_training_request;
    logic [2:0] fast_ctrl_channel_mode_p0;
    logic [2:0] fast_ctrl_channel_mode_p1;
    rrc_kind_t fast_ctrl_channel_kind_p0;
    rrc_kind_t fast_ctrl_channel_kind_p1;
    int fails = 0;
    int n_tests = 0;

    // 20 mhz clock
    always #25 clk = ~clk;

    rrc_caps_regs rrc_caps_regs_inst (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .second_port_view_select(second_port_view_select), .rx_lock(rx_lock),
        .bcc_mode_p0(bcc_mode_p0), .bcc_mode_p1(bcc_mode_p1), .bcc_freq(bcc_freq),
        .bcc_eq(bcc_eq), .reg_rdata(reg_rdata), .freq_training_request(freq_training_request),
        .eq_training_request(eq_training_request),
        .fast_ctrl_channel_mode_p0(fast_ctrl_channel_mode_p0),
        .fast_ctrl_channel_mode_p1(fast_ctrl_channel_mode_p1),
        .fast_ctrl_channel_kind_p0(fast_ctrl_channel_kind_p0),
        .fast_ctrl_channel_kind_p1(fast_ctrl_channel_kind_p1));

    rrc_remote_rx_model rrc_remote_rx_model_inst (.clk(clk), .rx_lock(rx_lock),
        .bcc_mode_p0(bcc_mode_p0), .bcc_mode_p1(bcc_mode_p1), .bcc_freq(bcc_freq),
        .bcc_eq(bcc_eq));

    // ------------------------------------------------------------
    // register access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        second_port_view_select <= s;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic s, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        second_port_view_select <= s;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // lock load lands on the third edge after lock rises; one spare edge
    task automatic wait_load();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // expected decode, worked out independently of the design
    function automatic rrc_kind_t exp_kind(input logic [2:0] m);
        case (m)
            3'h0: return RRC_KIND_NORMAL;
            3'h1: return RRC_KIND_GPIO1;
            3'h2: return RRC_KIND_GPIO2;
            3'h3: return RRC_KIND_GPIO4;
            3'h6: return RRC_KIND_FWD_SPI;
            3'h7: return RRC_KIND_REV_SPI;
            default: return RRC_KIND_RESERVED;
        endcase
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog: the tests need well under 1000 cycles
    // ------------------------------------------------------------
    initial
    begin
        #(5000 * 50);
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(freq_training_request, 2'h0)
        rd_chk(1'b0, RRC_CAPS1_OFFSET, RRC_RESET_VALUE);
        rd_chk(1'b0, RRC_CAPS2_OFFSET, RRC_RESET_VALUE);
        wr(1'b0, RRC_CAPS1_OFFSET, 8'hff);
        rd_chk(1'b0, RRC_CAPS1_OFFSET, 8'hf0);
        `CHK(freq_training_request, 2'h1)
        `CHK(eq_training_request, 2'h1)
        `CHK(fast_ctrl_channel_mode_p0, 3'h1)
        rd_chk(1'b1, RRC_CAPS1_OFFSET, 8'h00);
        wr(1'b0, 8'h26, 8'hff);
        rd_chk(1'b0, 8'h26, RRC_READ_ZERO);
        // every mode code through software with hold set
        for (int m = 0; m < 8; m++)
        begin
            wr(1'b0, RRC_CAPS1_OFFSET, {1'b1, m[0], 6'h00});
            wr(1'b0, RRC_CAPS2_OFFSET, {6'h00, m[2:1]});
            @(posedge clk);
            #1;
            `CHK(fast_ctrl_channel_mode_p0, m[2:0])
            `CHK(fast_ctrl_channel_kind_p0, exp_kind(m[2:0]))
        end
        // hold set: lock must not reload
        rrc_remote_rx_model_inst.lock_port(0, 3'h2, 1'b1, 1'b1, 0);
        wait_load();
        `CHK(freq_training_request, 2'h0)
        rd_chk(1'b0, RRC_CAPS1_OFFSET, 8'hc0);
        rd_chk(1'b0, RRC_CAPS2_OFFSET, 8'h03);
        // hold cleared: next lock reloads, slow remote this time
        wr(1'b0, RRC_CAPS1_OFFSET, 8'h00);
        rrc_remote_rx_model_inst.lock_port(0, 3'h5, 1'b1, 1'b0, 2);
        wait_load();
        `CHK(fast_ctrl_channel_mode_p0, 3'h5)
        `CHK(freq_training_request, 2'h1)
        `CHK(eq_training_request, 2'h0)
        rd_chk(1'b0, RRC_CAPS1_OFFSET, 8'h60);
        rd_chk(1'b0, RRC_CAPS2_OFFSET, 8'h02);
        `CHK(fast_ctrl_channel_kind_p0, RRC_KIND_RESERVED)
        // second port loads alone and is seen through the select bit
        rrc_remote_rx_model_inst.lock_port(1, 3'h7, 1'b0, 1'b1, 1);
        wait_load();
        `CHK(eq_training_request, 2'h2)
        `CHK(freq_training_request, 2'h1)
        `CHK(fast_ctrl_channel_mode_p1, 3'h7)
        rd_chk(1'b1, RRC_CAPS1_OFFSET, 8'h50);
        rd_chk(1'b1, RRC_CAPS2_OFFSET, 8'h03);
        rd_chk(1'b0, RRC_CAPS1_OFFSET, 8'h60);
        `CHK(fast_ctrl_channel_kind_p1, RRC_KIND_REV_SPI)
        // software override on the second port survives a relock
        wr(1'b1, RRC_CAPS1_OFFSET, 8'ha0);
        rrc_remote_rx_model_inst.lock_port(1, 3'h0, 1'b0, 1'b0, 0);
        wait_load();
        `CHK(freq_training_request, 2'h3)
        `CHK(fast_ctrl_channel_mode_p1, 3'h6)
        rd_chk(1'b1, RRC_CAPS1_OFFSET, 8'ha0);
        // upper mode bits written through the select bit land in port1 only
        wr(1'b1, RRC_CAPS2_OFFSET, 8'h01);
        rd_chk(1'b1, RRC_CAPS2_OFFSET, 8'h01);
        `CHK(fast_ctrl_channel_mode_p1, 3'h2)
        `CHK(fast_ctrl_channel_mode_p0, 3'h5)
        `CHK(fast_ctrl_channel_kind_p1, RRC_KIND_GPIO2)
        // with the clock enable low a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(1'b1, RRC_CAPS1_OFFSET, 8'h00);
        ce <= 1'b1;
        rd_chk(1'b1, RRC_CAPS1_OFFSET, 8'ha0);
        print_verdict();
    end
endmodule
